// >>> hdl/dcn_ms_tick.v
// dcn_ms_tick.v: one-cycle pulse every millisecond
// assumes the system clock given by the header
`timescale 1ns/1ps
`default_nettype none
`include "dcn_defs.vh"
module dcn_ms_tick #(
  parameter integer CYCLES = `DCN_CLK_HZ / `DCN_MS_PER_S
) (
  input wire i_clock,
  input wire i_nrst,
  output reg o_tick
);
  reg [15:0] cnt_reg;
  // divide the clock down to a millisecond pulse
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt_reg == CYCLES[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dcn_ms_timer.v
// dcn_ms_timer.v: millisecond interval counter with restart
// expires one cycle after the count of ticks reaches the limit
`timescale 1ns/1ps
`default_nettype none
module dcn_ms_timer #(
  parameter integer W = 16
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_run,
  input wire i_restart,
  input wire i_tick,
  input wire [W-1:0] i_limit,
  output reg o_expire
);
  reg [W-1:0] cnt_reg;
  // count ticks while running; pulse and restart at the limit
  always @(posedge i_clock) begin
    if (!i_nrst || !i_run || i_restart) begin
      cnt_reg <= {W{1'b0}};
      o_expire <= 1'b0;
    end else if (i_tick && (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= i_limit)) begin
      cnt_reg <= {W{1'b0}};
      o_expire <= 1'b1;
    end else begin
      if (i_tick)
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      o_expire <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dcn_node.v
// dcn_node.v: CAN node communication logic of a drive amplifier
// assumes a frame controller outside that delivers and sends decoded frames
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcn_defs.vh"
module dcn_node #(
  parameter integer MS_CYCLES = `DCN_CLK_HZ / `DCN_MS_PER_S
) (
  input wire i_clock,
  input wire i_nrst,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire [3:0] i_id_switch,
  input wire i_boot_done,
  input wire i_rx_valid,
  input wire [10:0] i_rx_id,
  input wire [63:0] i_rx_data,
  input wire i_guard_rx,
  input wire i_hb_rx,
  input wire [15:0] i_status_word,
  input wire [15:0] i_speed_act,
  input wire [15:0] i_drive_err,
  input wire i_tx_ready,
  output wire o_tx_valid,
  output reg [10:0] o_tx_id,
  output reg [63:0] o_tx_data,
  output reg [3:0] o_tx_len,
  output wire [6:0] o_node_id,
  output wire [6:0] o_baud_sel,
  output reg [15:0] o_ctrl_word,
  output reg [15:0] o_speed_ref,
  output reg [15:0] o_current_lim,
  output reg o_rx_strobe,
  output wire o_comm_err,
  output wire o_irq
);
  localparam S_IDLE = 3'b001;
  localparam S_PDO = 3'b010;
  localparam S_HB = 3'b100;

  reg [15:0] ctrl_reg;
  reg [6:0] paddr_reg;
  reg [15:0] life_reg;
  reg [15:0] hbprod_reg;
  reg [15:0] hbcons_reg;
  reg [15:0] txcyc_reg;
  reg [2:0] stat_reg;
  reg [2:0] mask_reg;
  reg [6:0] baud_reg;
  reg [2:0] chgsel_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg pdo_pend_reg;
  reg hb_pend_reg;
  reg [47:0] last_tx_reg;
  reg gap_ok_reg;
  reg booted_reg;
  reg [6:0] node_next;
  wire [1:0] addr_mode;
  wire [1:0] tx_mode;
  wire guard_on;
  wire hbc_on;
  wire oper;
  wire tick;
  wire guard_exp;
  wire hbc_exp;
  wire hbp_exp;
  wire cyc_exp;
  wire rx_hit;
  wire changed;
  wire pdo_start;
  wire hb_start;
  wire [2:0] ev;

  assign addr_mode = ctrl_reg[`DCN_C_ADDR_LO +: 2];
  assign tx_mode = ctrl_reg[`DCN_C_TX_LO +: 2];
  assign oper = ctrl_reg[`DCN_C_OPER];
  assign guard_on = ctrl_reg[`DCN_C_GUARD] & oper;
  assign hbc_on = ctrl_reg[`DCN_C_HBCONS] & ~ctrl_reg[`DCN_C_GUARD] & oper;
  assign o_baud_sel = baud_reg;

  // node identifier from the selected addressing mode
  always @* begin
    case (addr_mode)
      `DCN_ADDR_SW: node_next = {3'h0, i_id_switch} + 7'h01;
      `DCN_ADDR_SUM: node_next = {3'h0, i_id_switch} + paddr_reg + 7'h01;
      `DCN_ADDR_PROG: node_next = paddr_reg + 7'h01;
      default: node_next = {3'h0, i_id_switch} + 7'h01;
    endcase
  end
  assign o_node_id = node_next;

  // receive frame always accepted on its own identifier
  assign rx_hit = i_rx_valid && (i_rx_id == `DCN_ID_RX + {4'h0, node_next});
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_ctrl_word <= 16'h0000;
      o_speed_ref <= 16'h0000;
      o_current_lim <= 16'h0000;
      o_rx_strobe <= 1'b0;
    end else begin
      o_rx_strobe <= rx_hit;
      if (rx_hit) begin
        o_ctrl_word <= i_rx_data[15:0];
        o_speed_ref <= i_rx_data[31:16];
        o_current_lim <= i_rx_data[47:32];
      end
    end
  end

  dcn_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .o_tick(tick)
  );

  // supervision and period timers
  // guard timer: restarted by every guard message, idle outside operational state
  dcn_ms_timer u_guard (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(guard_on),
    .i_restart(i_guard_rx),
    .i_tick(tick),
    .i_limit(life_reg),
    .o_expire(guard_exp)
  );
  // consumer timer: held off while guarding is enabled
  dcn_ms_timer u_hbc (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(hbc_on),
    .i_restart(i_hb_rx),
    .i_tick(tick),
    .i_limit(hbcons_reg),
    .o_expire(hbc_exp)
  );
  // producer timer free-runs; a zero time would flood the bus, so it stops
  dcn_ms_timer u_hbp (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(booted_reg & ctrl_reg[`DCN_C_HBPROD] & (hbprod_reg != 16'h0000)),
    .i_restart(1'b0),
    .i_tick(tick),
    .i_limit(hbprod_reg),
    .o_expire(hbp_exp)
  );
  // cycle timer doubles as the minimum gap in change mode
  dcn_ms_timer u_cyc (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run((tx_mode == `DCN_TX_CYC) || (tx_mode == `DCN_TX_CHG)),
    .i_restart(pdo_start),
    .i_tick(tick),
    .i_limit(txcyc_reg),
    .o_expire(cyc_exp)
  );

  // change detection on selected transmit values
  assign changed = (chgsel_reg[0] && (i_status_word != last_tx_reg[15:0])) ||
                   (chgsel_reg[1] && (i_speed_act != last_tx_reg[31:16])) ||
                   (chgsel_reg[2] && (i_drive_err != last_tx_reg[47:32]));

  // transmit requests and boot latch
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      pdo_pend_reg <= 1'b0;
      hb_pend_reg <= 1'b0;
      gap_ok_reg <= 1'b1;
      booted_reg <= 1'b0;
    end else begin
      if (i_boot_done)
        booted_reg <= 1'b1;
      if (pdo_start)
        gap_ok_reg <= 1'b0;
      else if (cyc_exp || tx_mode != `DCN_TX_CHG)
        gap_ok_reg <= 1'b1;
      if (tx_mode == `DCN_TX_OFF)
        pdo_pend_reg <= 1'b0;
      else if ((tx_mode == `DCN_TX_CYC && cyc_exp) ||
               (tx_mode == `DCN_TX_RX && rx_hit) ||
               (tx_mode == `DCN_TX_CHG && changed && gap_ok_reg))
        pdo_pend_reg <= 1'b1;
      else if (pdo_start)
        pdo_pend_reg <= 1'b0;
      if (hbp_exp)
        hb_pend_reg <= 1'b1;
      else if (hb_start)
        hb_pend_reg <= 1'b0;
    end
  end

  // transmit state machine: heartbeat wins over process data
  assign hb_start = (state_reg == S_IDLE) && hb_pend_reg;
  assign pdo_start = (state_reg == S_IDLE) && !hb_pend_reg && pdo_pend_reg;
  assign o_tx_valid = (state_reg != S_IDLE);
  always @* begin
    case (state_reg)
      S_IDLE: state_next = hb_start ? S_HB : (pdo_start ? S_PDO : S_IDLE);
      S_PDO: state_next = i_tx_ready ? S_IDLE : S_PDO;
      S_HB: state_next = i_tx_ready ? S_IDLE : S_HB;
      default: state_next = S_IDLE;
    endcase
  end
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      state_reg <= S_IDLE;
      o_tx_id <= 11'h000;
      o_tx_data <= 64'h0;
      o_tx_len <= 4'h0;
      last_tx_reg <= 48'h0;
    end else begin
      state_reg <= state_next;
      if (hb_start) begin
        o_tx_id <= `DCN_ID_HB + {4'h0, node_next};
        o_tx_data <= {56'h0, 1'b0, oper ? 7'h05 : 7'h7f};
        o_tx_len <= 4'h1;
      end else if (pdo_start) begin
        o_tx_id <= `DCN_ID_TX + {4'h0, node_next};
        o_tx_data <= {16'h0, i_drive_err, i_speed_act, i_status_word};
        o_tx_len <= 4'h6;
        last_tx_reg <= {i_drive_err, i_speed_act, i_status_word};
      end
    end
  end

  // sticky status, write one to clear, set wins
  assign ev = {rx_hit, hbc_exp, guard_exp};
  assign o_comm_err = stat_reg[`DCN_S_GUARD] | stat_reg[`DCN_S_HBC];
  assign o_irq = |(stat_reg & mask_reg);
  always @(posedge i_clock) begin
    if (!i_nrst)
      stat_reg <= 3'h0;
    else if (i_wr && i_addr == `DCN_A_STAT)
      stat_reg <= (stat_reg & ~i_wdata[2:0]) | ev;
    else
      stat_reg <= stat_reg | ev;
  end

  // register writes
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_reg <= 16'h0000;
      paddr_reg <= 7'h00;
      life_reg <= `DCN_LIFE_RST;
      hbprod_reg <= 16'h0000;
      hbcons_reg <= 16'h0000;
      txcyc_reg <= 16'h0000;
      mask_reg <= 3'h0;
      baud_reg <= `DCN_BAUD_RST;
      chgsel_reg <= 3'h0;
    end else if (i_wr) begin
      case (i_addr)
        `DCN_A_CTRL: ctrl_reg <= i_wdata;
        `DCN_A_PADDR: paddr_reg <= i_wdata[6:0];
        `DCN_A_LIFE: life_reg <= i_wdata;
        `DCN_A_HBPROD: hbprod_reg <= i_wdata;
        `DCN_A_HBCONS: hbcons_reg <= i_wdata;
        `DCN_A_TXCYC: txcyc_reg <= i_wdata;
        `DCN_A_MASK: mask_reg <= i_wdata[2:0];
        `DCN_A_BAUD: baud_reg <= i_wdata[6:0];
        `DCN_A_CHGSEL: chgsel_reg <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge i_clock) begin
    if (!i_nrst)
      o_rdata <= 16'h0000;
    else if (i_rd) begin
      case (i_addr)
        `DCN_A_CTRL: o_rdata <= ctrl_reg;
        `DCN_A_PADDR: o_rdata <= {9'h000, paddr_reg};
        `DCN_A_LIFE: o_rdata <= life_reg;
        `DCN_A_HBPROD: o_rdata <= hbprod_reg;
        `DCN_A_HBCONS: o_rdata <= hbcons_reg;
        `DCN_A_TXCYC: o_rdata <= txcyc_reg;
        `DCN_A_STAT: o_rdata <= {13'h0000, stat_reg};
        `DCN_A_MASK: o_rdata <= {13'h0000, mask_reg};
        `DCN_A_NODE: o_rdata <= {9'h000, node_next};
        `DCN_A_BAUD: o_rdata <= {9'h000, baud_reg};
        `DCN_A_CHGSEL: o_rdata <= {13'h0000, chgsel_reg};
        default: o_rdata <= 16'h0000;
      endcase
    end else
      o_rdata <= 16'h0000;
  end
endmodule
`default_nettype wire

// >>> pkg/dcn_defs.vh
// dcn_defs.vh: constants for the drive node communication block
// assumes a 10 MHz clock and a plain strobe register port
`ifndef DCN_DEFS_VH
`define DCN_DEFS_VH
// register offsets
`define DCN_A_CTRL 4'h0
`define DCN_A_PADDR 4'h1
`define DCN_A_LIFE 4'h2
`define DCN_A_HBPROD 4'h3
`define DCN_A_HBCONS 4'h4
`define DCN_A_TXCYC 4'h5
`define DCN_A_STAT 4'h6
`define DCN_A_MASK 4'h7
`define DCN_A_NODE 4'h8
`define DCN_A_BAUD 4'h9
`define DCN_A_CHGSEL 4'ha
// control field positions
`define DCN_C_ADDR_LO 0
`define DCN_C_GUARD 2
`define DCN_C_HBPROD 3
`define DCN_C_HBCONS 4
`define DCN_C_OPER 5
`define DCN_C_TX_LO 6
// addressing modes
`define DCN_ADDR_SW 2'h0
`define DCN_ADDR_SUM 2'h1
`define DCN_ADDR_PROG 2'h2
// transmit triggers
`define DCN_TX_OFF 2'h0
`define DCN_TX_CYC 2'h1
`define DCN_TX_RX 2'h2
`define DCN_TX_CHG 2'h3
// frame identifier bases
`define DCN_ID_RX 11'h200
`define DCN_ID_TX 11'h180
`define DCN_ID_HB 11'h700
// reset values
`define DCN_LIFE_RST 16'h01f4
`define DCN_BAUD_RST 7'h01
// status bits
`define DCN_S_GUARD 0
`define DCN_S_HBC 1
`define DCN_S_RX 2
// time base
`define DCN_CLK_HZ 10000000
`define DCN_MS_PER_S 1000
`endif

// >>> tb/dcn_host.sv
// dcn_host.sv: host side model, takes frames and feeds supervision
// assumes frames offered by valid and held until ready
`timescale 1ns/1ps
`default_nettype none
module dcn_host (
  input wire logic i_clock,
  input wire logic i_stall,
  input wire logic [7:0] i_period,
  input wire logic i_tx_valid,
  input wire logic [10:0] i_tx_id,
  input wire logic [63:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_guard,
  output logic o_hb,
  output logic [10:0] o_last_id,
  output logic [63:0] o_last_data,
  output int o_count
);
  logic [7:0] cnt;
  initial begin
    {o_tx_ready, o_guard, o_hb, cnt, o_count} = 0;
  end
  // take frames, stall at random, pulse guard and heartbeat each period
  always @(posedge i_clock) begin
    if (i_tx_valid && o_tx_ready) begin
      o_last_id <= i_tx_id;
      o_last_data <= i_tx_data;
      o_count <= o_count + 1;
    end
    o_tx_ready <= !i_stall || $urandom_range(1) == 0;
    cnt <= (cnt + 8'h01 >= i_period) ? 8'h00 : cnt + 8'h01;
    o_guard <= i_period != 8'h00 && cnt == 8'h00;
    o_hb <= i_period != 8'h00 && cnt == 8'h00;
  end
endmodule
`default_nettype wire

// >>> tb/dcn_node_checker.sv
// dcn_node_checker.sv: port assertions for the drive node block
// assumes the bind below and the strobe register port
`timescale 1ns/1ps
`default_nettype none
`include "dcn_defs.vh"
module dcn_node_checker (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic i_rx_valid,
  input wire logic [10:0] i_rx_id,
  input wire logic [63:0] i_rx_data,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [10:0] o_tx_id,
  input wire logic [63:0] o_tx_data,
  input wire logic [3:0] o_tx_len,
  input wire logic [15:0] o_rdata,
  input wire logic [6:0] o_node_id,
  input wire logic [15:0] o_ctrl_word,
  input wire logic [15:0] o_speed_ref,
  input wire logic [15:0] o_current_lim,
  input wire logic o_rx_strobe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // receive frame addressed to this node
  wire logic hit = i_rx_valid && i_rx_id == 11'h200 + {4'h0, o_node_id};
  wire logic [10:0] hb_id = 11'h700 + {4'h0, o_node_id};
  node_nonzero_a: assert property (o_node_id != 7'h00)
    else $error("node id zero");
  rx_take_a: assert property (hit |=> o_rx_strobe && o_ctrl_word == $past(i_rx_data[15:0]))
    else $error("receive frame not taken");
  rx_map_a: assert property (hit |=> o_speed_ref == $past(i_rx_data[31:16])
    && o_current_lim == $past(i_rx_data[47:32])) else $error("receive fields misplaced");
  rx_drop_a: assert property (i_rx_valid && !hit |=> !o_rx_strobe)
    else $error("foreign frame taken");
  tx_ids_a: assert property (o_tx_valid |-> (o_tx_len == 4'h6 &&
    o_tx_id == 11'h180 + {4'h0, o_node_id}) || (o_tx_len == 4'h1 && o_tx_id == hb_id))
    else $error("bad transmit id");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("frame dropped while stalled");
  hb_state_a: assert property (o_tx_valid && o_tx_id == hb_id |->
    o_tx_data[7:0] inside {8'h05, 8'h7f}) else $error("bad heartbeat state");
  rd_node_a: assert property (i_rd && i_addr == `DCN_A_NODE |=>
    o_rdata == {9'h000, $past(o_node_id)}) else $error("node read wrong");
  cover property (hit);
  cover property (o_tx_valid && !i_tx_ready);
  cover property (o_tx_valid && o_tx_id == hb_id);
endmodule
bind dcn_node dcn_node_checker dcn_node_checker_i (.i_clock, .i_nrst, .i_addr, .i_rd,
  .i_rx_valid, .i_rx_id, .i_rx_data, .i_tx_ready, .o_tx_valid, .o_tx_id, .o_tx_data,
  .o_tx_len, .o_rdata, .o_node_id, .o_ctrl_word, .o_speed_ref, .o_current_lim, .o_rx_strobe);
`default_nettype wire

// >>> tb/tb.sv
// tb.sv: self-checking bench for the drive node block
// assumes dcn_node, dcn_host and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dcn_defs.vh"
module tb;
  logic i_clock, i_nrst, i_wr, i_rd, i_boot_done, i_rx_valid, stall;
  logic [3:0] i_addr, i_id_switch;
  logic [15:0] i_wdata, i_status_word, i_speed_act, i_drive_err;
  logic [10:0] i_rx_id;
  logic [63:0] i_rx_data, d;
  logic [7:0] period;
  wire logic [15:0] o_rdata, o_ctrl_word, o_speed_ref, o_current_lim;
  wire logic [63:0] o_tx_data, last_d;
  wire logic [10:0] o_tx_id, last_id;
  wire logic [6:0] o_node_id, o_baud_sel;
  wire logic [3:0] o_tx_len;
  wire logic o_tx_valid, o_rx_strobe, o_comm_err, o_irq, i_tx_ready, i_guard_rx, i_hb_rx;
  int failures, compares, hcount, nd, sw, pa, n0;
  dcn_node #(.MS_CYCLES(10)) dcn_node_i (.i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_id_switch, .i_boot_done, .i_rx_valid, .i_rx_id, .i_rx_data, .i_guard_rx,
    .i_hb_rx, .i_status_word, .i_speed_act, .i_drive_err, .i_tx_ready, .o_tx_valid, .o_tx_id,
    .o_tx_data, .o_tx_len, .o_node_id, .o_baud_sel, .o_ctrl_word, .o_speed_ref,
    .o_current_lim, .o_rx_strobe, .o_comm_err, .o_irq);
  dcn_host dcn_host_i (.i_clock, .i_stall(stall), .i_period(period), .i_tx_valid(o_tx_valid),
    .i_tx_id(o_tx_id), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_guard(i_guard_rx),
    .o_hb(i_hb_rx), .o_last_id(last_id), .o_last_data(last_d), .o_count(hcount));
  // node id model
  function automatic int nid(int m, int s, int p);
    return m == 0 ? s + 1 : m == 1 ? s + p + 1 : p + 1;
  endfunction
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clock) begin i_addr <= a; i_wdata <= v; i_wr <= 1'b1; end
    @(posedge i_clock) i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge i_clock) begin i_addr <= a; i_rd <= 1'b1; end
    @(posedge i_clock) i_rd <= 1'b0;
    #1 chk(nm, o_rdata, e);
  endtask
  task automatic rx(input logic [10:0] id, input logic [63:0] v);
    @(posedge i_clock) begin i_rx_id <= id; i_rx_data <= v; i_rx_valid <= 1'b1; end
    @(posedge i_clock) i_rx_valid <= 1'b0;
    #1;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic end_sim();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // watchdog
  initial begin
    #1000000 failures++;
    end_sim();
  end
  // main sequence
  initial begin
    {i_nrst, i_wr, i_rd, i_boot_done, i_rx_valid, stall, i_addr, i_id_switch, i_wdata} = 0;
    {i_status_word, i_speed_act, i_drive_err, i_rx_id, i_rx_data, period} = 0;
    n0 = $urandom(70);
    idle(3);
    i_nrst <= 1'b1;
    rd(`DCN_A_LIFE, 16'h01f4, "life reset");
    n0 = $urandom_range(127);
    wr(`DCN_A_BAUD, n0[15:0]);
    chk("baud select", o_baud_sel, n0[6:0]);
    for (int m = 0; m < 3; m++) begin
      sw = $urandom_range(15);
      pa = $urandom_range(m == 2 ? 126 : 110);
      nd = nid(m, sw, pa);
      @(posedge i_clock) i_id_switch <= sw[3:0];
      wr(`DCN_A_CTRL, m[15:0]);
      wr(`DCN_A_PADDR, pa[15:0]);
      rd(`DCN_A_NODE, nd[15:0], "node id");
    end
    d = {$urandom, $urandom};
    wr(`DCN_A_MASK, 16'h0004);
    rx(11'h200 + nd[10:0], d);
    chk("speed ref", o_speed_ref, d[31:16]);
    rx(11'h200 + nd[10:0] + 11'h001, ~d);
    chk("ctrl word", o_ctrl_word, d[15:0]);
    chk("irq raised", o_irq, 1'b1);
    wr(`DCN_A_STAT, 16'h0004);
    chk("irq cleared", o_irq, 1'b0);
    wr(`DCN_A_TXCYC, 16'h0002);
    wr(`DCN_A_CHGSEL, 16'h0001);
    @(posedge i_clock) stall <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      wr(`DCN_A_CTRL, {8'h00, t[1:0], 6'h02});
      n0 = hcount;
      @(posedge i_clock) begin i_status_word <= 16'($urandom); i_speed_act <= 16'($urandom); end
      if (t == 2) rx(11'h200 + nd[10:0], d);
      idle(60);
      chk("tx fired", hcount != n0, t != 0);
      if (t != 0) chk("tx id", last_id, 11'h180 + nd[10:0]);
      if (t != 0) chk("tx data", last_d[47:0], {i_drive_err, i_speed_act, i_status_word});
    end
    wr(`DCN_A_LIFE, 16'h0003);
    wr(`DCN_A_HBCONS, 16'h0002);
    @(posedge i_clock) period <= 8'd10;
    wr(`DCN_A_CTRL, 16'h0036);
    wr(`DCN_A_STAT, 16'h0007);
    idle(80);
    chk("guard fed", o_comm_err, 1'b0);
    @(posedge i_clock) period <= 8'd0;
    idle(80);
    rd(`DCN_A_STAT, 16'h0001, "guard only");
    chk("guard error", o_comm_err, 1'b1);
    wr(`DCN_A_CTRL, 16'h0032);
    wr(`DCN_A_STAT, 16'h0007);
    idle(80);
    rd(`DCN_A_STAT, 16'h0002, "consumer timeout");
    wr(`DCN_A_HBPROD, 16'h0002);
    @(posedge i_clock) i_boot_done <= 1'b1;
    wr(`DCN_A_CTRL, 16'h002a);
    idle(60);
    chk("heartbeat id", last_id, 11'h700 + nd[10:0]);
    chk("heartbeat state", last_d[7:0], 8'h05);
    end_sim();
  end
endmodule
`default_nettype wire
